/* File: rtl/ssp_short_protect.sv */
// switch short-circuit protection and gate drive gating
`timescale 1ns/1ps
module ssp_short_protect #(
  parameter int unsigned BLANK_CYCLES = ssp_pkg::BLANK_CYC,
  parameter int unsigned TRIP_COUNT = ssp_pkg::TRIP_LIMIT
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_adapter_present,
  input wire logic [ssp_pkg::OPT_W-1:0] i_charger_option_word,
  input wire logic i_hs_pwm,
  input wire logic i_ls_pwm,
  input wire logic [9:0] i_hs_drop_mv,
  input wire logic [9:0] i_ls_drop_mv,
  input wire logic i_nonsync_mode,
  input wire logic i_charge_undercurrent_guard,
  input wire logic i_boot_refresh,
  output logic o_hs_gate,
  output logic o_ls_gate,
  output logic o_latched_off,
  output logic [ssp_pkg::CNT_W-1:0] o_hs_count,
  output logic [ssp_pkg::CNT_W-1:0] o_ls_count
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ssp_pkg::ssp_state_t state;
  ssp_pkg::ssp_state_t next_state;
  logic adapter_q;
  logic hs_gate_q;
  logic ls_gate_q;
  logic [ssp_pkg::BLANK_W-1:0] blank_cnt;
  logic [ssp_pkg::BLANK_W-1:0] next_blank_cnt;
  logic hs_on_q;
  logic ls_on_q;
  logic [9:0] hs_thr;
  logic hs_trip;
  logic ls_trip;
  logic hs_done;
  logic ls_done;
  logic clr_cnt;
  logic edge_seen;
  logic blank_over;
  logic next_hs_gate;
  logic next_ls_gate;
  logic [ssp_pkg::CNT_W-1:0] hs_cnt_w;
  logic [ssp_pkg::CNT_W-1:0] ls_cnt_w;
  logic [ssp_pkg::CNT_W-1:0] next_hs_cnt_o;
  logic [ssp_pkg::CNT_W-1:0] next_ls_cnt_o;
  logic latched_q;
  logic next_latched;

  // ----------------------------------------------------------------
  // threshold select and comparators
  // ----------------------------------------------------------------
  // high threshold decoded from option bits; low one is a constant
  always_comb begin
    case (i_charger_option_word[ssp_pkg::HS_SEL_MSB:ssp_pkg::HS_SEL_LSB])
      2'h0: hs_thr = ssp_pkg::HS_THR0_MV;
      2'h1: hs_thr = ssp_pkg::HS_THR1_MV;
      2'h2: hs_thr = ssp_pkg::HS_THR2_MV;
      default: hs_thr = ssp_pkg::HS_THR3_MV;
    endcase
  end

  // a new switching edge restarts the blanking window
  assign edge_seen = (hs_gate_q != hs_on_q) || (ls_gate_q != ls_on_q);
  assign blank_over = (blank_cnt >= ssp_pkg::BLANK_W'(BLANK_CYCLES));

  // drops only count on the switch that conducts, after blanking
  assign hs_trip = (state == ssp_pkg::SSP_RUN) && hs_gate_q && blank_over
    && !edge_seen && (i_hs_drop_mv > hs_thr);
  assign ls_trip = (state == ssp_pkg::SSP_RUN) && ls_gate_q && blank_over
    && !edge_seen && (i_ls_drop_mv > ssp_pkg::LS_THR_MV);

  always_comb begin
    next_blank_cnt = blank_cnt;
    if (edge_seen) begin
      next_blank_cnt = '0;
    end else if (!blank_over) begin
      next_blank_cnt = blank_cnt + ssp_pkg::BLANK_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // occurrence counters
  // ----------------------------------------------------------------
  // counters restart on every new adapter connection
  assign clr_cnt = (state == ssp_pkg::SSP_OFF);

  ssp_trip_counter #(
    .W(ssp_pkg::CNT_W),
    .LIMIT(3'(TRIP_COUNT))
  ) u_hs_cnt (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_clear(clr_cnt),
    .i_trip(hs_trip),
    .o_count_done(hs_done),
    .o_count(hs_cnt_w)
  );

  ssp_trip_counter #(
    .W(ssp_pkg::CNT_W),
    .LIMIT(3'(TRIP_COUNT))
  ) u_ls_cnt (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_clear(clr_cnt),
    .i_trip(ls_trip),
    .o_count_done(ls_done),
    .o_count(ls_cnt_w)
  );

  // ----------------------------------------------------------------
  // latch-off state machine
  // ----------------------------------------------------------------
  // only an adapter removal leaves the latched state; nothing else
  always_comb begin
    next_state = state;
    case (state)
      ssp_pkg::SSP_OFF: begin
        if (adapter_q) begin
          next_state = ssp_pkg::SSP_RUN;
        end
      end
      ssp_pkg::SSP_RUN: begin
        if (!adapter_q) begin
          next_state = ssp_pkg::SSP_OFF;
        end else if (hs_done || ls_done) begin
          next_state = ssp_pkg::SSP_LATCHED;
        end
      end
      ssp_pkg::SSP_LATCHED: begin
        if (!adapter_q) begin
          next_state = ssp_pkg::SSP_OFF;
        end
      end
      default: next_state = ssp_pkg::SSP_OFF;
    endcase
  end

  // ----------------------------------------------------------------
  // gate drive
  // ----------------------------------------------------------------
  // low gate off in diode mode or undercurrent, bar boot refresh
  always_comb begin
    next_hs_gate = 1'b0;
    next_ls_gate = 1'b0;
    if (state == ssp_pkg::SSP_RUN && !(hs_done || ls_done)) begin
      next_hs_gate = i_hs_pwm && !i_ls_pwm;
      if (!i_hs_pwm && !i_nonsync_mode) begin
        next_ls_gate = i_ls_pwm && (!i_charge_undercurrent_guard
          || i_boot_refresh);
      end
    end
    // other states leave both gates at zero
    next_hs_cnt_o = hs_cnt_w;
    next_ls_cnt_o = ls_cnt_w;
    // latched flag registered so the output comes from a flop
    next_latched = (next_state == ssp_pkg::SSP_LATCHED);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // hs_on_q/ls_on_q remember the previous gate to spot edges
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state <= ssp_pkg::SSP_OFF;
      adapter_q <= 1'b0;
      hs_gate_q <= 1'b0;
      ls_gate_q <= 1'b0;
      hs_on_q <= 1'b0;
      ls_on_q <= 1'b0;
      blank_cnt <= '0;
      o_hs_count <= '0;
      o_ls_count <= '0;
      latched_q <= 1'b0;
    end else begin
      state <= next_state;
      adapter_q <= i_adapter_present;
      hs_gate_q <= next_hs_gate;
      ls_gate_q <= next_ls_gate;
      hs_on_q <= hs_gate_q;
      ls_on_q <= ls_gate_q;
      blank_cnt <= next_blank_cnt;
      o_hs_count <= next_hs_cnt_o;
      o_ls_count <= next_ls_cnt_o;
      latched_q <= next_latched;
    end
  end

  assign o_hs_gate = hs_gate_q;
  assign o_ls_gate = ls_gate_q;
  assign o_latched_off = latched_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_latch_gates;
    @(posedge i_clk) disable iff (i_sys_rst)
    o_latched_off |-> !o_hs_gate && !o_ls_gate;
  endproperty
  a_latch_gates: assert property (p_latch_gates)
    else $error("gate driven while latched off");

  property p_latch_hold;
    @(posedge i_clk) disable iff (i_sys_rst)
    o_latched_off && adapter_q |=> o_latched_off;
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latch cleared without adapter removal");

  property p_seven_latch;
    @(posedge i_clk) disable iff (i_sys_rst)
    (state == ssp_pkg::SSP_RUN) && adapter_q
      && (hs_cnt_w == 3'h7 || ls_cnt_w == 3'h7) |=> o_latched_off;
  endproperty
  a_seven_latch: assert property (p_seven_latch)
    else $error("seventh short did not latch off");

  property p_nonsync;
    @(posedge i_clk) disable iff (i_sys_rst)
    i_nonsync_mode |=> !o_ls_gate;
  endproperty
  a_nonsync: assert property (p_nonsync)
    else $error("low gate on in non-synchronous mode");

  property p_ucp;
    @(posedge i_clk) disable iff (i_sys_rst)
    i_charge_undercurrent_guard && !i_boot_refresh |=> !o_ls_gate;
  endproperty
  a_ucp: assert property (p_ucp)
    else $error("low gate on under undercurrent guard");

  property p_blank;
    @(posedge i_clk) disable iff (i_sys_rst)
    (hs_trip || ls_trip) |-> blank_cnt >= 8'(BLANK_CYCLES);
  endproperty
  a_blank: assert property (p_blank)
    else $error("trip counted inside blanking window");

  property p_hs_cnt;
    @(posedge i_clk) disable iff (i_sys_rst)
    hs_trip && !clr_cnt && !hs_done
      |=> hs_cnt_w == $past(hs_cnt_w) + 3'h1;
  endproperty
  a_hs_cnt: assert property (p_hs_cnt)
    else $error("high side counter did not advance");

  property p_ls_thr;
    @(posedge i_clk) disable iff (i_sys_rst)
    ls_trip |-> i_ls_drop_mv > 10'h06e;
  endproperty
  a_ls_thr: assert property (p_ls_thr)
    else $error("low side tripped below fixed level");

  property p_hs_thr;
    @(posedge i_clk) disable iff (i_sys_rst)
    hs_trip && i_charger_option_word[8:7] == 2'h0
      |-> i_hs_drop_mv > 10'h12c;
  endproperty
  a_hs_thr: assert property (p_hs_thr)
    else $error("high side tripped below 300mV setting");

  property p_clear;
    @(posedge i_clk) disable iff (i_sys_rst)
    state == ssp_pkg::SSP_OFF |=> hs_cnt_w == 3'h0 && ls_cnt_w == 3'h0;
  endproperty
  a_clear: assert property (p_clear)
    else $error("counters not cleared after adapter removal");
endmodule : ssp_short_protect

/* File: rtl/ssp_pkg.sv */
// package: constants for the switch short protection block
package ssp_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  // blanking after a switching edge, in ns
  localparam int unsigned BLANK_NS = 100;
  localparam int unsigned BLANK_CYC =
    ((BLANK_NS * (CLK_HZ / 1_000_000)) + 999) / 1000 < 1 ? 1 :
    ((BLANK_NS * (CLK_HZ / 1_000_000)) + 999) / 1000;
  localparam int unsigned TRIP_LIMIT = 7; // short events before latch-off
  localparam int unsigned CNT_W = 3;
  localparam int unsigned BLANK_W = 8;
  // charger option word field for the high-side threshold
  localparam int unsigned HS_SEL_LSB = 7;
  localparam int unsigned HS_SEL_MSB = 8;
  localparam int unsigned OPT_W = 16;
  // thresholds in mV
  localparam logic [9:0] LS_THR_MV = 10'h06e;  // 110 mV, fixed
  localparam logic [9:0] HS_THR0_MV = 10'h12c; // 300 mV
  localparam logic [9:0] HS_THR1_MV = 10'h1f4; // 500 mV
  localparam logic [9:0] HS_THR2_MV = 10'h2bc; // 700 mV
  localparam logic [9:0] HS_THR3_MV = 10'h384; // 900 mV
  typedef enum logic [2:0] {
    SSP_OFF = 3'b001,
    SSP_RUN = 3'b010,
    SSP_LATCHED = 3'b100
  } ssp_state_t;
endpackage : ssp_pkg

/* File: rtl/ssp_trip_counter.sv */
// occurrence counter for one over-current comparator
`timescale 1ns/1ps
module ssp_trip_counter #(
  parameter int unsigned W = 3,
  parameter logic [2:0] LIMIT = 3'h7
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_clear,
  input wire logic i_trip,
  output logic o_count_done,
  output logic [W-1:0] o_count
);
  logic [W-1:0] count;
  logic [W-1:0] next_count;

  // saturate at the limit so the done flag cannot wrap back off
  always_comb begin
    next_count = count;
    if (i_clear) begin
      next_count = '0;
    end else if (i_trip && count != W'(LIMIT)) begin
      next_count = count + W'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign o_count = count;
  assign o_count_done = (count == W'(LIMIT));
endmodule : ssp_trip_counter

/* File: testbench/ssp_switch_model.sv */
// partner model: the two external power switches seen as drops
`timescale 1ns/1ps
module ssp_switch_model (
  input wire logic i_clk,
  input wire logic i_hs_gate,
  input wire logic i_ls_gate,
  input wire logic i_hs_short,
  input wire logic i_ls_short,
  input wire logic [9:0] i_short_mv,
  output logic [9:0] o_hs_drop_mv,
  output logic [9:0] o_ls_drop_mv
);
  // an open switch has no meaningful drop: show a moving pattern
  logic [9:0] pat = 10'h2aa;
  always_ff @(posedge i_clk) begin
    pat <= ~pat;
  end
  // a closed switch shows a small drop, or the commanded fault drop
  assign o_hs_drop_mv = !i_hs_gate ? pat :
    (i_hs_short ? i_short_mv : 10'h014);
  assign o_ls_drop_mv = !i_ls_gate ? pat :
    (i_ls_short ? i_short_mv : 10'h00a);
endmodule : ssp_switch_model

/* File: testbench/ssp_short_protect_tb_top.sv */
// testbench for the switch short protection block
`timescale 1ns/1ps
module ssp_short_protect_tb_top;
  // ----------------------------------------
  // stimulus, design and switch model
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic adp = 1'b0;
  logic [ssp_pkg::OPT_W-1:0] opt = 16'h0000;
  logic hs_pwm = 1'b0, ls_pwm = 1'b0, nsync = 1'b0;
  logic guard = 1'b0, refr = 1'b0, hs_sh = 1'b0, ls_sh = 1'b0;
  logic [9:0] sh_mv = 10'h000;
  logic [9:0] hs_drop, ls_drop;
  logic hs_g, ls_g, lat;
  logic [2:0] hs_cnt, ls_cnt;
  int err_total = 0;
  int cmp_count = 0;
  always #12.5 clk = ~clk;
  ssp_short_protect ssp_short_protect_i (.i_clk(clk), .i_sys_rst(rst),
    .i_adapter_present(adp), .i_charger_option_word(opt),
    .i_hs_pwm(hs_pwm), .i_ls_pwm(ls_pwm), .i_hs_drop_mv(hs_drop),
    .i_ls_drop_mv(ls_drop), .i_nonsync_mode(nsync),
    .i_charge_undercurrent_guard(guard), .i_boot_refresh(refr),
    .o_hs_gate(hs_g), .o_ls_gate(ls_g), .o_latched_off(lat),
    .o_hs_count(hs_cnt), .o_ls_count(ls_cnt));
  ssp_switch_model ssp_switch_model_i (.i_clk(clk), .i_hs_gate(hs_g),
    .i_ls_gate(ls_g), .i_hs_short(hs_sh), .i_ls_short(ls_sh),
    .i_short_mv(sh_mv), .o_hs_drop_mv(hs_drop), .o_ls_drop_mv(ls_drop));
  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // drive on rising edges, judge on falling ones so updates have landed
  task automatic chk(input string what, input logic [9:0] got,
                     input logic [9:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s at %0t: got %h expected %h",
               what, $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  // wait for latch-off, then prove only an adapter replug clears it
  task automatic latch_replug(input logic [9:0] ehs, input logic [9:0] els);
    for (int i = 0; i < 40 && lat !== 1'b1; i++) begin
      @(negedge clk);
    end
    tick(10);
    @(negedge clk);
    chk("latched", {9'h0, lat}, 10'h001);
    chk("hs count", {7'h0, hs_cnt}, ehs);
    chk("ls count", {7'h0, ls_cnt}, els);
    chk("hs gate off", {9'h0, hs_g}, 10'h000);
    chk("ls gate off", {9'h0, ls_g}, 10'h000);
    // dropping the requests and the fault must not clear the latch
    tick(1);
    hs_pwm <= 1'b0;
    ls_pwm <= 1'b0;
    hs_sh <= 1'b0;
    ls_sh <= 1'b0;
    tick(4);
    @(negedge clk);
    chk("still latched", {9'h0, lat}, 10'h001);
    tick(1);
    adp <= 1'b0;
    tick(5);
    adp <= 1'b1;
    tick(4);
    @(negedge clk);
    chk("unlatched", {9'h0, lat}, 10'h000);
    chk("hs cleared", {7'h0, hs_cnt}, 10'h000);
    chk("ls cleared", {7'h0, ls_cnt}, 10'h000);
  endtask : latch_replug
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_hs(input logic [1:0] sel, input logic [9:0] thr);
    tick(1);
    opt <= {7'h00, sel, 7'h00};
    hs_sh <= 1'b1;
    sh_mv <= thr;
    hs_pwm <= 1'b1;
    tick(12);
    @(negedge clk);
    chk("hs gate on", {9'h0, hs_g}, 10'h001);
    chk("hs at thr", {7'h0, hs_cnt}, 10'h000);
    tick(1);
    hs_pwm <= 1'b0;
    tick(2);
    // raise the drop only while the switch is open, so no stale trip
    sh_mv <= thr + 10'h001;
    hs_pwm <= 1'b1;
    tick(6);
    @(negedge clk);
    chk("hs blank", {7'h0, hs_cnt}, 10'h000);
    latch_replug(10'h007, 10'h000);
    $display("high side trip done, select %0d", sel);
  endtask : t_hs
  task automatic t_ls();
    tick(1);
    ls_sh <= 1'b1;
    sh_mv <= ssp_pkg::LS_THR_MV;
    opt <= 16'hffff;
    ls_pwm <= 1'b1;
    tick(12);
    @(negedge clk);
    chk("ls at thr", {7'h0, ls_cnt}, 10'h000);
    tick(1);
    sh_mv <= ssp_pkg::LS_THR_MV + 10'h001;
    latch_replug(10'h000, 10'h007);
    $display("low side trip done");
  endtask : t_ls
  task automatic t_reset();
    tick(5);
    rst <= 1'b0;
    @(negedge clk);
    chk("reset latch", {9'h0, lat}, 10'h000);
    chk("reset count", {7'h0, hs_cnt}, 10'h000);
    chk("reset ls count", {7'h0, ls_cnt}, 10'h000);
    chk("reset gates", {8'h0, hs_g, ls_g}, 10'h000);
    $display("reset check done");
  endtask : t_reset
  task automatic t_ls_gate();
    tick(1);
    ls_pwm <= 1'b1;
    tick(3);
    @(negedge clk);
    chk("ls gate on", {9'h0, ls_g}, 10'h001);
    tick(1);
    nsync <= 1'b1;
    tick(3);
    @(negedge clk);
    chk("diode mode", {9'h0, ls_g}, 10'h000);
    tick(1);
    nsync <= 1'b0;
    guard <= 1'b1;
    tick(3);
    @(negedge clk);
    chk("guard", {9'h0, ls_g}, 10'h000);
    tick(1);
    refr <= 1'b1;
    tick(3);
    @(negedge clk);
    chk("refresh", {9'h0, ls_g}, 10'h001);
    tick(1);
    refr <= 1'b0;
    guard <= 1'b0;
    ls_pwm <= 1'b0;
    $display("low gate control done");
  endtask : t_ls_gate
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    t_reset();
    tick(1);
    adp <= 1'b1;
    tick(4);
    t_ls_gate();
    t_hs(2'h0, ssp_pkg::HS_THR0_MV);
    t_hs(2'h1, ssp_pkg::HS_THR1_MV);
    t_hs(2'h2, ssp_pkg::HS_THR2_MV);
    t_hs(2'h3, ssp_pkg::HS_THR3_MV);
    t_ls();
    give_verdict();
  end
  // the run needs some 300 cycles; over ten times that means a hang
  initial begin
    tick(4000);
    err_total++;
    give_verdict();
  end
endmodule : ssp_short_protect_tb_top
